// ==== design/vc1_pkg.sv ====
/*
  Shared constants for the virtual channel resource 1 control and status block:
  register offsets, field positions, reset values and arbitration table layout.
  Assumes a 12-bit APB byte address and 32-bit data.
*/
package vc1_pkg;

  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;

  // Register byte offsets
  localparam logic [11:0] CTL_OFFSET    = 12'h220;
  localparam logic [11:0] STS_OFFSET    = 12'h224;
  localparam logic [11:0] TBL_BASE      = 12'h260;
  localparam logic [11:0] TBL_LAST      = 12'h26C;

  // Arbitration table shape
  localparam int          TBL_WORDS     = 4;
  localparam int          TBL_IDX_W     = 2;
  localparam logic [1:0]  TBL_IDX_LAST  = 2'h3;

  // Control register fields
  localparam int          LOAD_BIT      = 16;
  localparam int          SCHEME_LSB    = 17;
  localparam int          SCHEME_MSB    = 19;
  localparam int          CHID_LSB      = 24;
  localparam int          CHID_MSB      = 26;
  localparam int          ENABLE_BIT    = 31;

  // Status register fields
  localparam int          COHERENCY_BIT = 16;
  localparam int          NEG_BIT       = 17;

  // Reset values
  localparam logic [2:0]  CHID_RST      = 3'h1;
  localparam logic        ENABLE_RST    = 1'h0;
  localparam logic [2:0]  SCHEME_RST    = 3'h0;
  localparam logic        COHERENCY_RST = 1'h0;
  localparam logic        NEG_RST       = 1'h0;

  // Arbitration schemes that read the table, one bit per scheme number
  localparam logic [7:0]  SCHEME_TABLE_MASK = 8'h38;

  // Loader latency from load start to done pulse, in cycles
  localparam int          LOAD_CYCLES   = 6;

  function automatic logic scheme_uses_table(input logic [2:0] sel);
    return SCHEME_TABLE_MASK[sel];
  endfunction

endpackage

// ==== design/arb_table_if.sv ====
/*
  Connection to the arbitration table memory: one write port and two read
  ports, one for register reads and one for the table loader.
  Assumes all users run on pclk.
*/
`timescale 1ns/1ps
interface arb_table_if;
  logic                            wr_en;
  logic [vc1_pkg::TBL_IDX_W-1:0]   wr_idx;
  logic [vc1_pkg::DATA_W-1:0]      wr_data;
  logic                            ra_en;
  logic [vc1_pkg::TBL_IDX_W-1:0]   ra_idx;
  logic [vc1_pkg::DATA_W-1:0]      ra_data;
  logic                            rb_en;
  logic [vc1_pkg::TBL_IDX_W-1:0]   rb_idx;
  logic [vc1_pkg::DATA_W-1:0]      rb_data;

  modport mem    (input wr_en, wr_idx, wr_data, ra_en, ra_idx, rb_en, rb_idx,
                  output ra_data, rb_data);
  modport regs   (output wr_en, wr_idx, wr_data, ra_en, ra_idx, input ra_data);
  modport loader (output rb_en, rb_idx, input rb_data);
endinterface

// ==== design/arb_table_mem.sv ====
/*
  Arbitration table storage with registered read data on both read ports.
  Assumes one clock and an asynchronous active-low reset that clears it.
*/
`timescale 1ns/1ps
module arb_table_mem (
  input wire logic          pclk,
  input wire logic          presetn,
  arb_table_if.mem          tif
);
  logic [vc1_pkg::DATA_W-1:0] mem_r [vc1_pkg::TBL_WORDS];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < vc1_pkg::TBL_WORDS; i++) begin
        mem_r[i] <= '0;
      end
      tif.ra_data <= '0;
      tif.rb_data <= '0;
    end else begin
      if (tif.wr_en) begin
        mem_r[tif.wr_idx] <= tif.wr_data;
      end
      if (tif.ra_en) begin
        tif.ra_data <= mem_r[tif.ra_idx];
      end
      if (tif.rb_en) begin
        tif.rb_data <= mem_r[tif.rb_idx];
      end
    end
  end
endmodule

// ==== design/arb_table_loader.sv ====
/*
  Streams the arbitration table words into the arbitration logic after a
  load start pulse, then pulses done together with the last word.
  Assumes start is only given while busy is low.
*/
`timescale 1ns/1ps
module arb_table_loader (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          start,
  arb_table_if.loader                        tif,
  output logic                               load_valid,
  output logic [vc1_pkg::TBL_IDX_W-1:0]      load_index,
  output logic [vc1_pkg::DATA_W-1:0]         load_data,
  output logic                               busy,
  output logic                               done
);
  typedef enum logic [1:0] {LD_IDLE, LD_READ, LD_DRAIN} ld_state_t;

  ld_state_t                        state_r, state_nxt;
  logic [vc1_pkg::TBL_IDX_W-1:0]    cnt_r, cnt_nxt;
  logic [vc1_pkg::TBL_IDX_W-1:0]    pidx_r, pidx_nxt;
  logic                             pend_r, pend_nxt;
  logic                             valid_r, valid_nxt;
  logic [vc1_pkg::TBL_IDX_W-1:0]    index_r, index_nxt;
  logic [vc1_pkg::DATA_W-1:0]       data_r, data_nxt;
  logic                             done_r, done_nxt;

  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    pidx_nxt   = pidx_r;
    pend_nxt   = 1'b0;
    tif.rb_en  = 1'b0;
    tif.rb_idx = cnt_r;
    done_nxt   = 1'b0;
    // Read data lands one cycle after the read is issued
    valid_nxt  = pend_r;
    index_nxt  = pend_r ? pidx_r : index_r;
    data_nxt   = pend_r ? tif.rb_data : data_r;
    case (state_r)
      LD_IDLE: begin
        if (start) begin
          state_nxt = LD_READ;
          cnt_nxt   = '0;
        end
      end
      LD_READ: begin
        tif.rb_en = 1'b1;
        pend_nxt  = 1'b1;
        pidx_nxt  = cnt_r;
        if (cnt_r == vc1_pkg::TBL_IDX_LAST) begin
          state_nxt = LD_DRAIN;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      LD_DRAIN: begin
        state_nxt = LD_IDLE;
        done_nxt  = 1'b1;
      end
      default: begin
        state_nxt = LD_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= LD_IDLE;
      cnt_r   <= '0;
      pidx_r  <= '0;
      pend_r  <= 1'b0;
      valid_r <= 1'b0;
      index_r <= '0;
      data_r  <= '0;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      pidx_r  <= pidx_nxt;
      pend_r  <= pend_nxt;
      valid_r <= valid_nxt;
      index_r <= index_nxt;
      data_r  <= data_nxt;
      done_r  <= done_nxt;
    end
  end

  assign load_valid = valid_r;
  assign load_index = index_r;
  assign load_data  = data_r;
  assign done       = done_r;
  assign busy       = (state_r != LD_IDLE) || valid_r;
endmodule

// ==== design/vc_resource1_ctl_status.sv ====
/*
  Control and status registers of virtual channel resource 1 with its port
  arbitration table, reached over APB, plus the table load sequence.
  Assumes one clock pclk, APB3 signalling and a synchronous negotiation input.
*/
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
//
// Behaviour
// - Control bits 26:24 hold a read-write channel identifier that resets to 1.
// - Control bit 31 is a read-write channel enable, reset clear, that runs the channel.
// - Any software write to the arbitration table sets status bit 16.
// - Status bit 16 only means something when the selected scheme uses the table.
// - Status bit 17 shows negotiation pending, reset clear.
// - Writing one to control bit 16 requests a table load; zero does nothing; it reads 0.
// - Control bits 19:17 are a read-write arbitration scheme select.
module vc_resource1_ctl_status (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [vc1_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [vc1_pkg::DATA_W-1:0]    pwdata,
  output logic                               pready,
  output logic [vc1_pkg::DATA_W-1:0]         prdata,
  output logic                               pslverr,
  input  wire logic                          negotiation_active,
  output logic                               channel_enable,
  output logic [2:0]                         channel_identifier,
  output logic [2:0]                         arbitration_scheme_select,
  output logic                               table_coherency_status,
  output logic                               load_valid,
  output logic [vc1_pkg::TBL_IDX_W-1:0]      load_index,
  output logic [vc1_pkg::DATA_W-1:0]         load_data,
  output logic                               load_busy
);
  arb_table_if tif ();

  logic                          enable_r, enable_nxt;
  logic [2:0]                    chid_r, chid_nxt;
  logic [2:0]                    scheme_r, scheme_nxt;
  logic                          coherency_r, coherency_nxt;
  logic                          rewritten_r, rewritten_nxt;
  logic                          neg_r, neg_nxt;
  logic [vc1_pkg::DATA_W-1:0]    prdata_r, prdata_nxt;
  logic                          rd_wait_r, rd_wait_nxt;

  logic                          is_ctl;
  logic                          is_sts;
  logic                          is_tbl;
  logic                          setup;
  logic                          wr_acc;
  logic                          rd_acc;
  logic                          load_start;
  logic                          load_done;
  logic [vc1_pkg::DATA_W-1:0]    ctl_word;
  logic [vc1_pkg::DATA_W-1:0]    sts_word;
  logic [vc1_pkg::ADDR_W-1:0]    tbl_off;

  // Address decode
  always_comb begin
    tbl_off = paddr - vc1_pkg::TBL_BASE;
    is_ctl  = (paddr == vc1_pkg::CTL_OFFSET);
    is_sts  = (paddr == vc1_pkg::STS_OFFSET);
    is_tbl  = (paddr >= vc1_pkg::TBL_BASE) && (paddr <= vc1_pkg::TBL_LAST)
              && (paddr[1:0] == 2'h0);
    setup   = psel && !penable;
    wr_acc  = psel && penable && pwrite && pready;
    rd_acc  = psel && penable && !pwrite && pready;
  end

  // Table reads cost one wait state, all else answers at once
  assign pready  = !rd_wait_r;
  assign pslverr = psel && penable && pready && !(is_ctl || is_sts || is_tbl);
  assign prdata  = prdata_r;

  // Read images; load request bit and reserved ranges are constant zero
  always_comb begin
    ctl_word = '0;
    ctl_word[vc1_pkg::ENABLE_BIT] = enable_r;
    ctl_word[vc1_pkg::CHID_MSB:vc1_pkg::CHID_LSB] = chid_r;
    ctl_word[vc1_pkg::SCHEME_MSB:vc1_pkg::SCHEME_LSB] = scheme_r;
    ctl_word[vc1_pkg::LOAD_BIT] = 1'b0;
    sts_word = '0;
    sts_word[vc1_pkg::COHERENCY_BIT] = coherency_r;
    sts_word[vc1_pkg::NEG_BIT] = neg_r;
  end

  // Table ports
  always_comb begin
    tif.wr_en   = wr_acc && is_tbl;
    tif.wr_idx  = tbl_off[vc1_pkg::TBL_IDX_W+1:2];
    tif.wr_data = pwdata;
    tif.ra_en   = setup && !pwrite && is_tbl;
    tif.ra_idx  = tbl_off[vc1_pkg::TBL_IDX_W+1:2];
  end

  // A load is only meaningful for table-driven schemes; the scheme written in
  // the same access counts. Requests during a running load are dropped.
  assign load_start = wr_acc && is_ctl && pwdata[vc1_pkg::LOAD_BIT]
                      && vc1_pkg::scheme_uses_table(pwdata[vc1_pkg::SCHEME_MSB:vc1_pkg::SCHEME_LSB])
                      && !load_busy;

  // Control and status next values
  always_comb begin
    enable_nxt    = enable_r;
    chid_nxt      = chid_r;
    scheme_nxt    = scheme_r;
    coherency_nxt = coherency_r;
    rewritten_nxt = rewritten_r;
    neg_nxt       = negotiation_active;
    if (wr_acc && is_ctl) begin
      enable_nxt = pwdata[vc1_pkg::ENABLE_BIT];
      chid_nxt   = pwdata[vc1_pkg::CHID_MSB:vc1_pkg::CHID_LSB];
      scheme_nxt = pwdata[vc1_pkg::SCHEME_MSB:vc1_pkg::SCHEME_LSB];
    end
    // Writes that land during a load keep the bit set after that load
    if (load_start) begin
      rewritten_nxt = 1'b0;
    end
    if (tif.wr_en && load_busy) begin
      rewritten_nxt = 1'b1;
    end
    if (load_done && !rewritten_r) begin
      coherency_nxt = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (tif.wr_en) begin
      coherency_nxt = 1'b1;
    end
  end

  // Read data path
  always_comb begin
    prdata_nxt  = prdata_r;
    rd_wait_nxt = rd_wait_r;
    if (setup && !pwrite) begin
      prdata_nxt  = is_ctl ? ctl_word : (is_sts ? sts_word : '0);
      rd_wait_nxt = is_tbl;
    end else if (rd_wait_r) begin
      prdata_nxt  = tif.ra_data;
      rd_wait_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r    <= vc1_pkg::ENABLE_RST;
      chid_r      <= vc1_pkg::CHID_RST;
      scheme_r    <= vc1_pkg::SCHEME_RST;
      coherency_r <= vc1_pkg::COHERENCY_RST;
      rewritten_r <= 1'b0;
      neg_r       <= vc1_pkg::NEG_RST;
      prdata_r    <= '0;
      rd_wait_r   <= 1'b0;
    end else begin
      enable_r    <= enable_nxt;
      chid_r      <= chid_nxt;
      scheme_r    <= scheme_nxt;
      coherency_r <= coherency_nxt;
      rewritten_r <= rewritten_nxt;
      neg_r       <= neg_nxt;
      prdata_r    <= prdata_nxt;
      rd_wait_r   <= rd_wait_nxt;
    end
  end

  assign channel_enable            = enable_r;
  assign channel_identifier        = chid_r;
  assign arbitration_scheme_select = scheme_r;
  assign table_coherency_status    = coherency_r;

  arb_table_mem u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .tif     (tif.mem)
  );

  arb_table_loader u_loader (
    .pclk       (pclk),
    .presetn    (presetn),
    .start      (load_start),
    .tif        (tif.loader),
    .load_valid (load_valid),
    .load_index (load_index),
    .load_data  (load_data),
    .busy       (load_busy),
    .done       (load_done)
  );

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic ctl_wr;
  logic ctl_rd;
  logic sts_rd;
  assign ctl_wr = wr_acc && is_ctl;
  assign ctl_rd = rd_acc && is_ctl;
  assign sts_rd = rd_acc && is_sts;

  a_chid_write: assert property (ctl_wr |=> channel_identifier == $past(pwdata[26:24]))
    else $error("channel identifier did not take the written value");

  a_enable_write: assert property (ctl_wr |=> channel_enable == $past(pwdata[31]))
    else $error("channel enable did not take the written value");

  a_table_sets_status: assert property (tif.wr_en |=> table_coherency_status)
    else $error("table write did not set coherency status");

  a_status_clear_cause: assert property ($fell(table_coherency_status) |-> $past(load_done))
    else $error("coherency status cleared without a finished load");

  a_load_timing: assert property (load_start |-> ##6 load_done)
    else $error("table load did not finish in six cycles");

  a_load_scheme_gate: assert property (ctl_wr && pwdata[16] && !load_busy &&
    !vc1_pkg::scheme_uses_table(pwdata[19:17]) |=> !load_busy)
    else $error("load started for a scheme without a table");

  a_neg_follows: assert property (##1 sts_rd |-> prdata[17] == $past(neg_r))
    else $error("negotiation bit read back wrong");

  a_load_reads_zero: assert property (ctl_rd |-> prdata[16] == 1'b0)
    else $error("load request bit read back as one");

  a_scheme_write: assert property (ctl_wr |=> arbitration_scheme_select == $past(pwdata[19:17]))
    else $error("scheme select did not take the written value");

  a_ctl_reserved: assert property (ctl_rd |-> (prdata & 32'h78F1FFFF) == 32'h00000000)
    else $error("control reserved bits not zero");

  a_sts_reserved: assert property (sts_rd |-> (prdata & 32'hFFFCFFFF) == 32'h00000000)
    else $error("status reserved bits not zero");

  // Fields move only on a control write, so a stray decode shows up here
  a_reset_values: assert property ($rose(presetn) |->
    channel_identifier == vc1_pkg::CHID_RST && channel_enable == vc1_pkg::ENABLE_RST)
    else $error("control fields not at reset values");

  a_chid_hold: assert property (
    !ctl_wr |=> $stable(channel_identifier))
    else $error("channel identifier changed without a control write");

  a_enable_hold: assert property (
    !ctl_wr |=> $stable(channel_enable))
    else $error("channel enable changed without a control write");

  a_scheme_hold: assert property (
    !ctl_wr |=> $stable(arbitration_scheme_select))
    else $error("scheme select changed without a control write");

  a_status_hold: assert property (
    table_coherency_status && !load_done |=> table_coherency_status)
    else $error("coherency status cleared outside a finished load");

  a_status_rise: assert property (
    $rose(table_coherency_status) |-> $past(tif.wr_en))
    else $error("coherency status set without a table write");

  a_neg_sample: assert property (
    1'b1 |=> neg_r == $past(negotiation_active))
    else $error("negotiation bit does not follow its input");

  a_sts_write_ignored: assert property (
    wr_acc && is_sts && !load_done |=> $stable(table_coherency_status))
    else $error("status write changed the coherency bit");

  a_unmapped_read: assert property (
    rd_acc && !(is_ctl || is_sts || is_tbl) |-> prdata == 32'h00000000 && pslverr)
    else $error("unmapped read did not return zero with an error");

  a_reg_zero_wait: assert property (
    psel && penable && (is_ctl || is_sts) |-> pready && !pslverr)
    else $error("register access was not answered at once");

  // A table read costs one wait state for the registered memory port
  a_table_read_wait: assert property (
    psel && $rose(penable) && !pwrite && is_tbl |-> !pready ##1 pready)
    else $error("table read wait state wrong");

  // Every word once, in index order, then the loader lets go
  a_load_stream: assert property (
    load_start |-> ##3 (load_valid && load_index == 2'h0) ##1 load_valid ##1 load_valid
    ##1 (load_valid && load_done))
    else $error("table load stream out of shape");

  a_stream_order: assert property (
    load_valid && load_index != vc1_pkg::TBL_IDX_LAST |=>
    load_valid && load_index == $past(load_index) + 2'h1)
    else $error("table words not streamed in index order");

  a_busy_span: assert property (
    load_start |=> load_busy [*6] ##1 !load_busy)
    else $error("loader busy span wrong");

  a_done_last: assert property (
    load_done |-> load_valid && load_index == vc1_pkg::TBL_IDX_LAST)
    else $error("load done not with the last word");

  c_table_write:  cover property (tif.wr_en ##1 table_coherency_status);
  c_full_load:    cover property (load_start ##[1:8] $fell(table_coherency_status));
  c_write_in_load: cover property (load_busy && tif.wr_en);
  c_bad_address:  cover property (pslverr);
  c_neg_pending:  cover property ($rose(neg_r));
endmodule

// ==== verification/tb_vc_resource1_ctl_status.sv ====
/*
  Self-checking bench for the channel resource 1 control and status block.
  Assumes the design files are compiled first; drives APB3 from the bench.
*/
`timescale 1ns/1ps
module tb_vc_resource1_ctl_status;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        negotiation_active;
  logic        channel_enable;
  logic [2:0]  channel_identifier;
  logic [2:0]  arbitration_scheme_select;
  logic        table_coherency_status;
  logic        load_valid;
  logic [1:0]  load_index;
  logic [31:0] load_data;
  logic        load_busy;
  logic [31:0] load_seen [4];
  logic [31:0] tbl [4];
  int          load_count;
  logic        busy_seen;
  int          failures;
  int          samples_checked;

  vc_resource1_ctl_status dut (
    .pclk                      (pclk),
    .presetn                   (presetn),
    .psel                      (psel),
    .penable                   (penable),
    .pwrite                    (pwrite),
    .paddr                     (paddr),
    .pwdata                    (pwdata),
    .pready                    (pready),
    .prdata                    (prdata),
    .pslverr                   (pslverr),
    .negotiation_active        (negotiation_active),
    .channel_enable            (channel_enable),
    .channel_identifier        (channel_identifier),
    .arbitration_scheme_select (arbitration_scheme_select),
    .table_coherency_status    (table_coherency_status),
    .load_valid                (load_valid),
    .load_index                (load_index),
    .load_data                 (load_data),
    .load_busy                 (load_busy)
  );

  initial pclk = 1'b0;
  always #2 pclk = ~pclk;

  // Sampled mid-cycle so the stream is read where it has settled
  always @(negedge pclk) begin
    if (load_valid === 1'b1) begin
      load_seen[load_index] = load_data;
      load_count++;
    end
    if (load_busy === 1'b1) busy_seen = 1'b1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen 0x%08h expected 0x%08h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // One idle edge first so psel is never assigned twice in one step
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Sampled at the rising edge itself, before that edge's updates land
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] addr, input logic [31:0] wd, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, addr, wd, rd, err);
    check({31'h0, err}, {31'h0, exp_err});
  endtask

  task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, addr, 32'h0, rd, err);
    check(rd, exp);
    check({31'h0, err}, {31'h0, exp_err});
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge pclk);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    complete_run();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; negotiation_active = 1'b0;
    load_count = 0; busy_seen = 1'b0; failures = 0; samples_checked = 0;
    for (int i = 0; i < 4; i++) tbl[i] = 32'hA5C30000 + 32'h00001111 * i;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;

    check({29'h0, channel_identifier}, 32'h1);
    rd_chk(vc1_pkg::CTL_OFFSET, 32'h01000000, 1'b0);
    rd_chk(vc1_pkg::STS_OFFSET, 32'h00000000, 1'b0);
    $display("test reset values done");

    // Scheme 7 does not use the table, so the load bit must be dropped
    wr(vc1_pkg::CTL_OFFSET, 32'hFFFFFFFF, 1'b0);
    cycles(1);
    check({31'h0, channel_enable}, 32'h1);
    check({29'h0, channel_identifier}, 32'h7);
    check({29'h0, arbitration_scheme_select}, 32'h7);
    rd_chk(vc1_pkg::CTL_OFFSET, 32'h870E0000, 1'b0);
    check(load_count, 32'h0);
    wr(vc1_pkg::CTL_OFFSET, 32'h00000000, 1'b0);
    cycles(1);
    check({31'h0, channel_enable}, 32'h0);
    rd_chk(vc1_pkg::CTL_OFFSET, 32'h00000000, 1'b0);
    $display("test control fields done");

    wr(vc1_pkg::STS_OFFSET, 32'hFFFFFFFF, 1'b0);
    rd_chk(vc1_pkg::STS_OFFSET, 32'h00000000, 1'b0);
    negotiation_active <= 1'b1;
    cycles(3);
    rd_chk(vc1_pkg::STS_OFFSET, 32'h00020000, 1'b0);
    negotiation_active <= 1'b0;
    cycles(3);
    rd_chk(vc1_pkg::STS_OFFSET, 32'h00000000, 1'b0);
    $display("test status done");

    for (int i = 0; i < 4; i++) wr(vc1_pkg::TBL_BASE + 12'(4 * i), tbl[i], 1'b0);
    cycles(1);
    check({31'h0, table_coherency_status}, 32'h1);
    rd_chk(vc1_pkg::STS_OFFSET, 32'h00010000, 1'b0);
    rd_chk(vc1_pkg::TBL_BASE + 12'h8, tbl[2], 1'b0);
    // Scheme 2 does not read the table: the request is dropped
    wr(vc1_pkg::CTL_OFFSET, 32'h00050000, 1'b0);
    cycles(12);
    check(load_count, 32'h0);
    rd_chk(vc1_pkg::STS_OFFSET, 32'h00010000, 1'b0);
    // Table scheme 3 with the load bit clear must not start a load
    wr(vc1_pkg::CTL_OFFSET, 32'h00060000, 1'b0);
    cycles(12);
    check(load_count, 32'h0);
    wr(vc1_pkg::CTL_OFFSET, 32'h00070000, 1'b0);
    for (int n = 0; n < 30 && load_count < 4; n++) @(posedge pclk);
    cycles(3);
    check(load_count, 32'h4);
    check({31'h0, busy_seen}, 32'h1);
    for (int i = 0; i < 4; i++) check(load_seen[i], tbl[i]);
    rd_chk(vc1_pkg::STS_OFFSET, 32'h00000000, 1'b0);
    rd_chk(vc1_pkg::CTL_OFFSET, 32'h00060000, 1'b0);
    $display("test table load done");

    wr(vc1_pkg::TBL_BASE, 32'h12345678, 1'b0);
    rd_chk(vc1_pkg::STS_OFFSET, 32'h00010000, 1'b0);
    wr(12'h300, 32'hFFFFFFFF, 1'b1);
    rd_chk(12'h300, 32'h00000000, 1'b1);
    rd_chk(vc1_pkg::CTL_OFFSET, 32'h00060000, 1'b0);
    $display("test unmapped done");

    // A table write while the load runs must leave the status set afterwards
    wr(vc1_pkg::CTL_OFFSET, 32'h00070000, 1'b0);
    wr(vc1_pkg::TBL_BASE + 12'h4, tbl[1], 1'b0);
    cycles(12);
    check(load_count, 32'h8);
    rd_chk(vc1_pkg::STS_OFFSET, 32'h00010000, 1'b0);
    $display("test write during load done");
    complete_run();
  end
endmodule
